// ### abx_exec.sv
// Single-cycle execute unit for transfer, stack, add, AND, compare, complement,
// call and loop-count branch instructions.
// Assumes the caller supplies external source data and the prefix byte each cycle.
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] Nibble swap exchanges nibbles inside each accumulator byte, updating sign only.
// [RULE_02] Software never uses the active accumulator as source of implied-destination ops.
// [RULE_03] Transfer from pointer-selected accumulator never targets the active accumulator.
// [RULE_04] Software never pushes and pops together or changes the stack pointer twice.
// [RULE_05] Setting the pointer clear bit zeroes the pointer, overriding auto update.
// [RULE_06] Auto pointer update wins over moving the accumulator into the pointer.
// [RULE_07] Bit set and clear serve only module 8 and modules 0 to 5.
// [RULE_08] Bit ops change C or E on flags, S or Z on pointer targets.
// [RULE_09] Add sums accumulator and source, updating carry, sign, zero and overflow.
// [RULE_10] Add with carry also adds the carry flag, same flag updates.
// [RULE_11] Byte sources take their upper byte from the prefix register.
// [RULE_12] AND combines accumulator and source bitwise, updating sign and zero.
// [RULE_13] Carry-bit AND ands carry with an indexed accumulator bit into carry.
// [RULE_14] Narrow variant software uses only bit indices zero through seven.
// [RULE_15] Short call pushes next address and branches relative, +127/-128 words.
// [RULE_16] Long immediate call branches absolute with prefix as upper byte.
// [RULE_17] Register-operand call always branches absolute to a 16-bit address.
// [RULE_18] Compare sets equal on match, clears otherwise, touching nothing else.
// [RULE_19] Complement inverts the active accumulator, updating sign and zero.
// [RULE_20] Carry complement inverts carry and nothing else.
// [RULE_21] Count-down branch decrements counter, branches while nonzero, flags untouched.
// [RULE_22] Push pre-increments then writes; pop reads then decrements; service pop clears flag.
module abx_exec (
  // Clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               reset_in,
  // Instruction and operands
  input  wire logic [15:0]        instr_in,
  input  wire logic               instr_valid_in,
  input  wire logic [15:0]        src_data_in,
  input  wire logic               src_byte_in,
  input  wire logic [7:0]         prefix_in,
  input  wire logic               prefix_valid_in,
  input  wire logic               service_enter_in,
  // Architectural state
  output logic [15:0]             ip_out,
  output logic [15:0]             acc_out,
  output logic [3:0]              ap_out,
  output logic [7:0]              apc_out,
  output logic [7:0]              flags_out,
  output logic [3:0]              sp_out,
  output logic [15:0]             lc0_out,
  output logic [15:0]             lc1_out,
  output logic                    in_service_out,
  // External register write
  output abx_pkg::abx_wr_t        ext_wr_out
);

  abx_pkg::abx_state_t r;
  abx_pkg::abx_state_t n;
  logic [15:0] act;
  logic [15:0] opnd;
  logic [15:0] wd;
  logic [15:0] tgt;
  logic [16:0] sum;
  logic [7:0]  tv;
  logic [7:0]  s;
  logic [6:0]  d;
  logic        f;
  logic        auto_up;
  logic        sz;
  logic        sz_late;
  logic        dwr;
  logic        clr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.wr = '0;
    act = r.acc[r.ap];
    f = instr_in[15];
    s = instr_in[7:0];
    d = instr_in[14:8];
    tv = 8'h00;
    auto_up = 1'b0;
    sz = 1'b0;
    sz_late = 1'b0;
    dwr = 1'b0;
    clr = 1'b0;
    // [RULE_11] prefix upper byte
    opnd = src_byte_in ? {prefix_in, src_data_in[7:0]} : src_data_in;
    if (!f) begin
      opnd = {prefix_in, s};
    end else if (s[3:0] == 4'h9) begin
      opnd = r.acc[s[7:4]];
    end else if (s == abx_pkg::S_ACC || s == abx_pkg::S_AAP) begin
      opnd = act;
    end else if (s == abx_pkg::S_AP) begin
      opnd = {12'h000, r.ap};
    end else if (s == abx_pkg::S_APC) begin
      opnd = {8'h00, r.pointer_control};
    end else if (s == abx_pkg::S_PSF) begin
      opnd = {8'h00, r.flag_register};
    end else if (s == abx_pkg::S_IP) begin
      opnd = r.ip;
    end else if (s == abx_pkg::S_POP || s == abx_pkg::S_POP_FROM_SERVICE) begin
      opnd = r.stk[r.sp];
    end else if (s == abx_pkg::S_SP) begin
      opnd = {12'h000, r.sp};
    end else if (s[7:5] == 3'h3 && s[3:0] == 4'hD) begin
      opnd = r.lc[s[4]];
    end
    wd = opnd;
    // [RULE_15] relative short target, [RULE_16] [RULE_17] absolute otherwise
    tgt = (!f && !prefix_valid_in) ? r.ip + {{8{s[7]}}, s} : opnd;
    sum = {1'b0, act} + {1'b0, opnd}
        + {16'h0000, (d == abx_pkg::G_ADD_WITH_CARRY) & r.flag_register[abx_pkg::F_C]};
    if (instr_valid_in) begin
      n.ip = r.ip + 16'h0001;
      if (instr_in == abx_pkg::OP_SWAP) begin
        // [RULE_01] nibble swap
        n.acc[r.ap] = {act[11:8], act[15:12], act[3:0], act[7:4]};
        n.flag_register[abx_pkg::F_S] = act[11];
        auto_up = 1'b1;
      end else if (instr_in == abx_pkg::OP_INV) begin
        // [RULE_19] accumulator complement
        n.acc[r.ap] = ~act;
        sz = 1'b1;
        auto_up = 1'b1;
      end else if (instr_in == abx_pkg::OP_INVC) begin
        // [RULE_20] carry complement
        n.flag_register[abx_pkg::F_C] = ~r.flag_register[abx_pkg::F_C];
      end else if (instr_in == abx_pkg::OP_NOP) begin
        n.ip = r.ip + 16'h0001;
      end else if (instr_in[15:8] == abx_pkg::OP_ANDB && instr_in[3:0] == 4'hA) begin
        // [RULE_13] carry and accumulator bit
        n.flag_register[abx_pkg::F_C] = r.flag_register[abx_pkg::F_C] & act[instr_in[7:4]];
      end else if (f && instr_in[3:0] == 4'h7) begin
        // [RULE_07] bit set and clear on supported modules
        if (d == abx_pkg::D_AP || d == abx_pkg::D_APC || d == abx_pkg::D_PSF) begin
          tv = (d == abx_pkg::D_AP) ? {4'h0, r.ap}
             : (d == abx_pkg::D_APC) ? r.pointer_control : r.flag_register;
          tv[instr_in[6:4]] = instr_in[7];
          wd = {8'h00, tv};
          dwr = 1'b1;
        end else if (d[3:0] == 4'h8 || (!d[3] && d[2:0] <= abx_pkg::MOD_LAST)) begin
          n.wr.we = 1'b1;
          n.wr.bit_op = 1'b1;
          n.wr.code = d;
          n.wr.data = {12'h000, instr_in[7:4]};
        end
      end else if (d == abx_pkg::G_AND) begin
        // [RULE_12] logical AND
        n.acc[r.ap] = act & opnd;
        sz = 1'b1;
        auto_up = 1'b1;
      end else if (d == abx_pkg::G_ADD || d == abx_pkg::G_ADD_WITH_CARRY) begin
        // [RULE_09] [RULE_10] add and add with carry
        n.acc[r.ap] = sum[15:0];
        n.flag_register[abx_pkg::F_C] = sum[16];
        n.flag_register[abx_pkg::F_OV] = (act[15] == opnd[15]) && (sum[15] != act[15]);
        sz = 1'b1;
        auto_up = 1'b1;
      end else if (d == abx_pkg::G_CMP) begin
        // [RULE_18] equality compare
        n.flag_register[abx_pkg::F_E] = (act == opnd);
      end else if (d == abx_pkg::G_CALL) begin
        // [RULE_15] push return address
        n.sp = r.sp + 4'h1;
        n.stk[n.sp] = r.ip + 16'h0001;
        n.ip = tgt;
      end else if (d[6:5] == 2'h2 && d[3:0] == 4'hD) begin
        // [RULE_21] count-down branch
        n.lc[d[4]] = r.lc[d[4]] - 16'h0001;
        if (n.lc[d[4]] != 16'h0000) begin
          n.ip = tgt;
        end
      end else if ((d[3:0] == 4'hA && d != abx_pkg::D_ACC) || d[3:0] == 4'hC
                   || (d == abx_pkg::D_ACC && f && s[3:0] == 4'hA)) begin
        n.ip = r.ip + 16'h0001;
      end else begin
        dwr = 1'b1;
        auto_up = f && (s == abx_pkg::S_ACC);
      end
      // [RULE_22] pop reads then decrements
      if (dwr && f && (s == abx_pkg::S_POP || s == abx_pkg::S_POP_FROM_SERVICE)
          && instr_in[3:0] != 4'h7) begin
        n.sp = r.sp - 4'h1;
        if (s == abx_pkg::S_POP_FROM_SERVICE) begin
          n.in_service_flag = 1'b0;
        end
      end
      if (dwr) begin
        if (d == abx_pkg::D_ACC) begin
          n.acc[r.ap] = wd;
          sz = 1'b1;
        end else if (d[3:0] == 4'h9) begin
          n.acc[{1'b0, d[6:4]}] = wd;
          sz = 1'b1;
        end else if (d == abx_pkg::D_AP) begin
          n.ap = wd[3:0];
          sz_late = 1'b1;
        end else if (d == abx_pkg::D_APC) begin
          n.pointer_control = {1'b0, wd[6:0]};
          clr = wd[abx_pkg::POINTER_CLEAR_BIT];
          sz_late = 1'b1;
        end else if (d == abx_pkg::D_PSF) begin
          // [RULE_08] bit ops reach C and E here
          n.flag_register = wd[7:0];
        end else if (d == abx_pkg::D_PUSH) begin
          // [RULE_22] push pre-increments
          n.sp = r.sp + 4'h1;
          n.stk[n.sp] = wd;
        end else if (d == abx_pkg::D_SP) begin
          n.sp = wd[3:0];
        end else if (d[6:5] == 2'h3 && d[3:0] == 4'hD) begin
          n.lc[d[4]] = wd;
        end else if (d != abx_pkg::D_NUL) begin
          n.wr.we = 1'b1;
          n.wr.code = d;
          n.wr.data = wd;
        end
      end
      if (sz) begin
        n.flag_register[abx_pkg::F_S] = n.acc[n.ap][15];
        n.flag_register[abx_pkg::F_Z] = (n.acc[n.ap] == 16'h0000);
      end
      // [RULE_06] auto update overrides the pointer transfer
      if (auto_up && r.pointer_control[1:0] == abx_pkg::MODE_INC) begin
        n.ap = r.ap + 4'h1;
      end else if (auto_up && r.pointer_control[1:0] == abx_pkg::MODE_DEC) begin
        n.ap = r.ap - 4'h1;
      end
      // [RULE_05] clear bit zeroes the pointer
      if (clr) begin
        n.ap = 4'h0;
      end
      // [RULE_08] pointer targets refresh S and Z
      if (sz_late) begin
        n.flag_register[abx_pkg::F_S] = n.acc[n.ap][15];
        n.flag_register[abx_pkg::F_Z] = (n.acc[n.ap] == 16'h0000);
      end
    end
    if (service_enter_in) begin
      n.in_service_flag = 1'b1;
    end
    n.view = n.acc[n.ap];
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ip_out         = r.ip;
  assign acc_out        = r.view;
  assign ap_out         = r.ap;
  assign apc_out        = r.pointer_control;
  assign flags_out      = r.flag_register;
  assign sp_out         = r.sp;
  assign lc0_out        = r.lc[0];
  assign lc1_out        = r.lc[1];
  assign in_service_out = r.in_service_flag;
  assign ext_wr_out     = r.wr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  swap_nibble_a: assert property ( // RULE_01
    instr_valid_in && instr_in == abx_pkg::OP_SWAP && apc_out[1:0] == 2'h0
    |=> acc_out == {$past(acc_out[11:8]), $past(acc_out[15:12]),
                    $past(acc_out[3:0]), $past(acc_out[7:4])})
    else $error("nibble swap result wrong");

  carry_invert_a: assert property ( // RULE_20
    instr_valid_in && instr_in == abx_pkg::OP_INVC
    |=> flags_out[abx_pkg::F_C] != $past(flags_out[abx_pkg::F_C])
        && acc_out == $past(acc_out))
    else $error("carry complement wrong");

  add_result_a: assert property ( // RULE_09
    instr_valid_in && instr_in[15:8] == {1'b0, abx_pkg::G_ADD} && apc_out[1:0] == 2'h0
    |=> acc_out == $past(acc_out) + $past({prefix_in, instr_in[7:0]}))
    else $error("add result wrong");

  cmp_equal_a: assert property ( // RULE_18
    instr_valid_in && instr_in[15:8] == {1'b0, abx_pkg::G_CMP}
    |=> flags_out[abx_pkg::F_E] == ($past(acc_out) == $past({prefix_in, instr_in[7:0]}))
        && acc_out == $past(acc_out) && flags_out[0] == $past(flags_out[0]))
    else $error("compare wrong");

  call_push_a: assert property ( // RULE_15
    instr_valid_in && instr_in[14:8] == abx_pkg::G_CALL
    |=> sp_out == $past(sp_out) + 4'h1)
    else $error("call did not push");

  count_fall_a: assert property ( // RULE_21
    instr_valid_in && instr_in[15:8] == 8'h4D && lc0_out == 16'h0001
    |=> lc0_out == 16'h0000 && ip_out == $past(ip_out) + 16'h0001)
    else $error("count-down fall-through wrong");

  and_carry_a: assert property ( // RULE_13
    instr_valid_in && instr_in[15:8] == abx_pkg::OP_ANDB && instr_in[3:0] == 4'hA
    |=> flags_out[abx_pkg::F_C]
        == ($past(flags_out[abx_pkg::F_C]) & $past(acc_out[instr_in[7:4]])))
    else $error("carry bit AND wrong");

  clear_pointer_a: assert property ( // RULE_05
    instr_valid_in && instr_in == 16'h980A && acc_out[abx_pkg::POINTER_CLEAR_BIT]
    |=> ap_out == 4'h0)
    else $error("pointer not cleared");

  pop_service_a: assert property ( // RULE_22
    instr_valid_in && instr_in == {1'b1, abx_pkg::D_ACC, abx_pkg::S_POP_FROM_SERVICE} && !service_enter_in
    |=> !in_service_out && sp_out == $past(sp_out) - 4'h1)
    else $error("service pop wrong");

endmodule : abx_exec

// ### abx_pkg.sv
// Constants, opcodes and carrier types for the accumulator/branch execute unit.
// Assumes 16-bit instruction words and a 16-bit accumulator datapath.
package abx_pkg;

  // ----------------------------------------------------------------
  // Whole-word opcodes and the carry-AND upper byte
  // ----------------------------------------------------------------
  localparam logic [15:0] OP_SWAP  = 16'h8A7A;
  localparam logic [15:0] OP_INV   = 16'h8A1A;
  localparam logic [15:0] OP_INVC  = 16'hDA2A;
  localparam logic [15:0] OP_NOP   = 16'hDA3A;
  localparam logic [7:0]  OP_ANDB  = 8'h9A;

  // ----------------------------------------------------------------
  // Operation groups in bits 14:8
  // ----------------------------------------------------------------
  localparam logic [6:0]  G_AND    = 7'h1A;
  localparam logic [6:0]  G_ADD    = 7'h4A;
  localparam logic [6:0]  G_ADD_WITH_CARRY   = 7'h6A;
  localparam logic [6:0]  G_CMP    = 7'h78;
  localparam logic [6:0]  G_CALL   = 7'h3D;

  // ----------------------------------------------------------------
  // Destination and source codes
  // ----------------------------------------------------------------
  localparam logic [6:0]  D_ACC    = 7'h0A;
  localparam logic [6:0]  D_AP     = 7'h08;
  localparam logic [6:0]  D_APC    = 7'h18;
  localparam logic [6:0]  D_PSF    = 7'h48;
  localparam logic [6:0]  D_PUSH   = 7'h0D;
  localparam logic [6:0]  D_SP     = 7'h1D;
  localparam logic [6:0]  D_NUL    = 7'h76;
  localparam logic [7:0]  S_ACC    = 8'h0A;
  localparam logic [7:0]  S_AAP    = 8'h1A;
  localparam logic [7:0]  S_AP     = 8'h08;
  localparam logic [7:0]  S_APC    = 8'h18;
  localparam logic [7:0]  S_PSF    = 8'h48;
  localparam logic [7:0]  S_IP     = 8'h0C;
  localparam logic [7:0]  S_POP    = 8'h0D;
  localparam logic [7:0]  S_POP_FROM_SERVICE   = 8'h8D;
  localparam logic [7:0]  S_SP     = 8'h1D;
  localparam logic [2:0]  MOD_LAST = 3'h5;

  // ----------------------------------------------------------------
  // Flag and pointer control fields
  // ----------------------------------------------------------------
  localparam int          F_C      = 0;
  localparam int          F_E      = 1;
  localparam int          F_OV     = 2;
  localparam int          F_S      = 3;
  localparam int          F_Z      = 4;
  localparam int          POINTER_CLEAR_BIT  = 7;
  localparam logic [1:0]  MODE_INC = 2'h1;
  localparam logic [1:0]  MODE_DEC = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        we;
    logic        bit_op;
    logic [6:0]  code;
    logic [15:0] data;
  } abx_wr_t;

  typedef struct packed {
    logic [15:0][15:0] acc;
    logic [15:0][15:0] stk;
    logic [3:0]        ap;
    logic [7:0]        pointer_control;
    logic [7:0]        flag_register;
    logic [15:0]       ip;
    logic [3:0]        sp;
    logic [1:0][15:0]  lc;
    logic              in_service_flag;
    logic [15:0]       view;
    abx_wr_t           wr;
  } abx_state_t;

endpackage : abx_pkg

// ### abx_tb.sv
// Self-checking bench for the accumulator/branch execute unit.
// Assumes abx_pkg and abx_exec are compiled ahead of this file.
`timescale 1ns/1ps

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              sys_clk_in       = 1'b0;
  logic              reset_in         = 1'b1;
  logic [15:0]       instr_in         = 16'h0000;
  logic              instr_valid_in   = 1'b0;
  logic [15:0]       src_data_in      = 16'h0000;
  logic              src_byte_in      = 1'b0;
  logic [7:0]        prefix_in        = 8'h00;
  logic              prefix_valid_in  = 1'b0;
  logic              service_enter_in = 1'b0;
  logic [15:0]       ip_out;
  logic [15:0]       acc_out;
  logic [3:0]        ap_out;
  logic [7:0]        apc_out;
  logic [7:0]        flags_out;
  logic [3:0]        sp_out;
  logic [15:0]       lc0_out;
  logic [15:0]       lc1_out;
  logic              in_service_out;
  abx_pkg::abx_wr_t  ext_wr_out;
  int                failures    = 0;
  int                comparisons = 0;
  int                cycles      = 0;
  logic [15:0]       ip_exp      = 16'h0000;
  logic [15:0]       k;

  abx_exec dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .src_data_in(src_data_in), .src_byte_in(src_byte_in),
    .prefix_in(prefix_in), .prefix_valid_in(prefix_valid_in),
    .service_enter_in(service_enter_in), .ip_out(ip_out), .acc_out(acc_out),
    .ap_out(ap_out), .apc_out(apc_out), .flags_out(flags_out), .sp_out(sp_out),
    .lc0_out(lc0_out), .lc1_out(lc1_out), .in_service_out(in_service_out),
    .ext_wr_out(ext_wr_out)
  );

  always #10 sys_clk_in = ~sys_clk_in;

  // The whole run needs well under a thousand cycles.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("BAD t=%0t run did not finish", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Issues one instruction and returns once its results are registered.
  task automatic run(input logic [15:0] in_service_flag, input logic [15:0] src = 16'h0000,
                     input logic byt = 1'b0, input logic [7:0] high_byte_prefix = 8'h00,
                     input logic pv = 1'b0);
    @(posedge sys_clk_in);
    instr_in <= in_service_flag;
    instr_valid_in <= 1'b1;
    src_data_in <= src;
    src_byte_in <= byt;
    prefix_in <= high_byte_prefix;
    prefix_valid_in <= pv;
    @(posedge sys_clk_in);
    instr_valid_in <= 1'b0;
    src_byte_in <= 1'b0;
    prefix_valid_in <= 1'b0;
    #1;
    ip_exp = ip_exp + 16'h0001;
  endtask : run

  // Loads the accumulator and flags, runs one operation with s driven as external source data.
  task automatic alu(input logic [15:0] in_service_flag, input logic [15:0] a, input logic [15:0] s,
                     input logic [7:0] flag_register, input logic [15:0] eacc, input logic [4:0] efl);
    run({8'h0A, a[7:0]}, 16'h0000, 1'b0, a[15:8]);
    run({8'h48, flag_register});
    run(in_service_flag, s);
    chk({16'h0000, acc_out}, {16'h0000, eacc}, "acc");
    chk({27'h0, flags_out[4:0]}, {27'h0, efl}, "flags");
    chk({16'h0000, ip_out}, {16'h0000, ip_exp}, "ip");
  endtask : alu

  // Calls, checks target and push, then pops the return address back.
  task automatic call_chk(input logic [15:0] in_service_flag, input logic [15:0] src, input logic byt,
                          input logic [7:0] high_byte_prefix, input logic pv, input logic [15:0] tgt);
    k = ip_exp;
    run(in_service_flag, src, byt, high_byte_prefix, pv);
    ip_exp = tgt;
    chk({16'h0000, ip_out}, {16'h0000, tgt}, "call target");
    chk({28'h0, sp_out}, 32'h1, "call push");
    run(16'h8A0D);
    chk({16'h0000, acc_out}, {16'h0000, k + 16'h0001}, "return address");
    chk({28'h0, sp_out}, 32'h0, "pop");
  endtask : call_chk

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1;
    chk({acc_out, ip_out}, 32'h0, "reset acc ip");
    chk({8'h00, flags_out, sp_out, ap_out, apc_out}, 32'h0, "reset flags");
    $display("test reset done");
    alu(16'hCA0E, 16'h2345, 16'hFF0F, 8'h02, 16'h2254, 5'b00011);
    alu(16'h4AC0, 16'h2345, 16'h0000, 8'h02, 16'h2405, 5'b00010);
    alu(16'hCA0E, 16'h2345, 16'h6789, 8'h00, 16'h8ACE, 5'b01100);
    alu(16'hEA0E, 16'h2345, 16'hDCBA, 8'h01, 16'h0000, 5'b10001);
    alu(16'hEA0E, 16'h2345, 16'h00EE, 8'h01, 16'h2434, 5'b00000);
    alu(16'h9A0E, 16'h2345, 16'h0F0F, 8'h07, 16'h0305, 5'b00111);
    alu(16'h9A0E, 16'h2345, 16'hDCBA, 8'h00, 16'h0000, 5'b10000);
    alu(16'hF80E, 16'h2345, 16'h2345, 8'h19, 16'h2345, 5'b11011);
    alu(16'hF80E, 16'h2345, 16'h2344, 8'h02, 16'h2345, 5'b00000);
    alu(16'h7845, 16'h0045, 16'h0000, 8'h00, 16'h0045, 5'b00010);
    alu(16'h8A1A, 16'hFFFF, 16'h0000, 8'h08, 16'h0000, 5'b10000);
    alu(16'h8A1A, 16'h0009, 16'h0000, 8'h10, 16'hFFF6, 5'b01000);
    alu(16'hDA2A, 16'h1234, 16'h0000, 8'h00, 16'h1234, 5'b00001);
    alu(16'hDA2A, 16'h1234, 16'h0000, 8'h1F, 16'h1234, 5'b11110);
    alu(16'h8A7A, 16'h0F00, 16'h0000, 8'h11, 16'hF000, 5'b11001);
    alu(16'h8A7A, 16'h1234, 16'h0000, 8'h08, 16'h2143, 5'b00000);
    alu(16'h9A0A, 16'h2345, 16'h0000, 8'h01, 16'h2345, 5'b00001);
    alu(16'h9A1A, 16'h2345, 16'h0000, 8'h01, 16'h2345, 5'b00000);
    alu(16'h9A8A, 16'h2345, 16'h0000, 8'h01, 16'h2345, 5'b00001);
    alu(16'h9AFA, 16'h2345, 16'h0000, 8'h01, 16'h2345, 5'b00000);
    alu(16'hDA3A, 16'h2345, 16'h0000, 8'h05, 16'h2345, 5'b00101);
    alu(16'h8A0E, 16'hFFFF, 16'hFF56, 8'h00, 16'hFF56, 5'b01000);
    run(16'h8A0E, 16'hFF56, 1'b1, 8'hAB);
    chk({16'h0000, acc_out}, 32'h0000AB56, "byte source");
    $display("test alu done");
    call_chk(16'h3D10, 16'h0000, 1'b0, 8'h00, 1'b0, ip_exp + 16'h0010);
    call_chk(16'h3D7F, 16'h0000, 1'b0, 8'h00, 1'b0, ip_exp + 16'h007F);
    call_chk(16'h3D80, 16'h0000, 1'b0, 8'h00, 1'b0, ip_exp - 16'h0080);
    call_chk(16'h3D20, 16'h0000, 1'b0, 8'h01, 1'b1, 16'h0120);
    call_chk(16'hBD0E, 16'h4567, 1'b0, 8'h00, 1'b0, 16'h4567);
    call_chk(16'hBD0E, 16'h9933, 1'b1, 8'h22, 1'b0, 16'h2233);
    $display("test call done");
    run(16'h0D77, 16'h0000, 1'b0, 8'h66);
    chk({28'h0, sp_out}, 32'h1, "push");
    @(posedge sys_clk_in);
    service_enter_in <= 1'b1;
    @(posedge sys_clk_in);
    service_enter_in <= 1'b0;
    #1;
    chk({31'h0, in_service_out}, 32'h1, "service set");
    run(16'h8A8D);
    chk({15'h0, in_service_out, acc_out}, 32'h00006677, "service pop");
    chk({28'h0, sp_out}, 32'h0, "service pop sp");
    $display("test stack done");
    run(16'h4800);
    run(16'h6D02);
    k = ip_exp;
    run(16'h4D05);
    ip_exp = k + 16'h0005;
    chk({lc0_out, ip_out}, {16'h0001, ip_exp}, "count branch");
    run(16'h4D05);
    chk({lc0_out, ip_out}, {16'h0000, ip_exp}, "count fall");
    run(16'h7D01);
    run(16'h5D09);
    chk({lc1_out, ip_out}, {16'h0000, ip_exp}, "count second");
    chk({24'h0, flags_out}, 32'h0, "count flags");
    $display("test count done");
    run(16'hC887);
    chk({24'h0, flags_out}, 32'h01, "bit set carry");
    run(16'hC897);
    run(16'hC807);
    chk({24'h0, flags_out}, 32'h02, "bit equal");
    run(16'h80B7);
    chk({7'h00, ext_wr_out}, {7'h00, 1'b1, 1'b1, 7'h00, 16'h000B}, "module 0");
    run(16'h85B7);
    chk({7'h00, ext_wr_out}, {7'h00, 1'b1, 1'b1, 7'h05, 16'h000B}, "module 5");
    run(16'h86B7);
    chk({31'h0, ext_wr_out.we}, 32'h0, "module 6");
    $display("test bit done");
    run(16'h1801);
    run(16'h0A05);
    run(16'h880A);
    chk({28'h0, ap_out}, 32'h1, "auto update wins");
    run(16'h0A81);
    run(16'h980A);
    chk({20'h0, ap_out, apc_out}, 32'h001, "pointer clear");
    $display("test pointer done");
    wrap_up();
  end
endmodule : tb
